// *** verilog/ccs_map.vh ***
// register offsets, field positions and reset values for clock output control
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// register offsets (8-bit register address space)
`define CCS_REG_IMASK 8'h06
`define CCS_REG_ADDRLSB 8'h1b
`define CCS_REG_OUTSEL 8'h1f
`define CCS_REG_OUTDIV0 8'h20
`define CCS_REG_OUTDIS 8'h6e
`define CCS_REG_LIVE 8'hda
`define CCS_REG_OUTEN 8'he6
`define CCS_REG_SOFTRST 8'hf6
`define CCS_REG_STICKY 8'hf7

// status bit positions
`define CCS_ST_CAL 0
`define CCS_ST_LOSCLK 2
`define CCS_ST_LOSFB 3
`define CCS_ST_LOL 4
`define CCS_ST_MASK 8'h1d

// soft reset value and field positions
`define CCS_SOFTRST_BIT 1
`define CCS_OUTEN_ALL 4

// output source codes (3 bits)
`define CCS_SRC_OWN 3'h0
`define CCS_SRC_FIRST 3'h1
`define CCS_SRC_OSC 3'h2
`define CCS_SRC_REF 3'h3
`define CCS_SRC_REFDIV 3'h4
`define CCS_SRC_FB 3'h5
`define CCS_SRC_FBDIV 3'h6

// stopped state codes
`define CCS_STOP_TRI 2'h0
`define CCS_STOP_LOW 2'h1
`define CCS_STOP_HIGH 2'h2
`define CCS_STOP_ON 2'h3

// calibration hold after reset, cycles
`define CCS_CAL_CYCLES 16'h0040

`endif

// *** verilog/ccs_cfg_store.v ***
// one-time programmable configuration store, registered read
`timescale 1ns/10ps
module ccs_cfg_store (
  // clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // read port
  input wire [2:0] rd_addr,
  output reg [7:0] rd_data,
  // programming port
  input wire prog_en,
  input wire [2:0] prog_addr,
  input wire [7:0] prog_data,
  output reg programmed_r
);
  reg [7:0] mem [0:7];
  integer i;

  // writes are accepted only until byte 7 has been programmed
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  always @(posedge REF_CLK) begin
    if (prog_en && !programmed_r) begin
      mem[prog_addr] <= prog_data;
    end
  end

  // the fuse state itself survives reset in silicon; here reset clears it
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      programmed_r <= 1'b0;
    end else if (prog_en && prog_addr == 3'h7) begin
      programmed_r <= 1'b1;
    end
  end

  initial begin
    for (i = 0; i < 8; i = i + 1) begin
      mem[i] = 8'h00;
    end
  end
endmodule // ccs_cfg_store

// *** verilog/ccs_out_lane.v ***
// one output lane: source select, post divider, stop state
`timescale 1ns/10ps
`include "ccs_map.vh"
module ccs_out_lane (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // sources
  input wire own_clk,
  input wire first_clk,
  input wire [4:0] in_stage,
  // configuration
  input wire [2:0] src_sel,
  input wire [2:0] div_sel,
  input wire [1:0] stop_state,
  input wire run,
  // result
  output reg out_val,
  output reg out_oe_n,
  output reg align_ok
);
  reg src_now;
  reg src_d_r;
  reg [4:0] cnt_r;
  reg [4:0] cnt_nxt;
  reg div_r;
  wire rise;

  always @* begin
    case (src_sel)
      `CCS_SRC_OWN: src_now = own_clk;
      `CCS_SRC_FIRST: src_now = first_clk;
      `CCS_SRC_OSC: src_now = in_stage[0];
      `CCS_SRC_REF: src_now = in_stage[1];
      `CCS_SRC_REFDIV: src_now = in_stage[2];
      `CCS_SRC_FB: src_now = in_stage[3];
      `CCS_SRC_FBDIV: src_now = in_stage[4];
      default: src_now = own_clk;
    endcase
  end

  assign rise = src_now && !src_d_r;

  // post divider counts source rising edges; div code n gives 2^n, codes 5 to 7 give 32
  always @* begin
    cnt_nxt = cnt_r;
    if (rise) begin
      cnt_nxt = cnt_r + 5'h01;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_d_r <= 1'b0;
      cnt_r <= 5'h00;
      div_r <= 1'b0;
      out_val <= 1'b0;
      out_oe_n <= 1'b1;
      align_ok <= 1'b0;
    end else begin
      src_d_r <= src_now;
      cnt_r <= cnt_nxt;
      if (div_sel == 3'h0) begin
        div_r <= src_now;
      end else if (div_sel == 3'h1) begin
        div_r <= cnt_nxt[0];
      end else if (div_sel == 3'h2) begin
        div_r <= cnt_nxt[1];
      end else if (div_sel == 3'h3) begin
        div_r <= cnt_nxt[2];
      end else if (div_sel == 3'h4) begin
        div_r <= cnt_nxt[3];
      end else begin
        div_r <= cnt_nxt[4];
      end
      // bypassed or divided outputs cannot be phase aligned
      align_ok <= (div_sel == 3'h0) &&
        (src_sel == `CCS_SRC_OWN || src_sel == `CCS_SRC_FIRST);
      if (run || stop_state == `CCS_STOP_ON) begin
        out_val <= div_r;
        out_oe_n <= 1'b0;
      end else begin
        out_val <= (stop_state == `CCS_STOP_HIGH);
        out_oe_n <= (stop_state == `CCS_STOP_TRI);
      end
    end
  end
endmodule // ccs_out_lane

// *** verilog/ccs_top.v ***
// clock output selection, enable and status register logic
`timescale 1ns/10ps
`include "ccs_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - after default load each output takes its own synthesis divider
// - any output may bypass the PLL from an input-stage signal
// - bypassed outputs are excluded from phase alignment
// - any output may select the first synthesis divider for fan-out
// - post divider of 1,2,4,8,16,32; divide by one after reset
// - no phase alignment when post divider is not one
// - on lock loss each output sits in its configured stopped state
// - always-on outputs ignore disables; host sets fed-back output always-on
// - each output enabled or disabled by register write
// - one global disable pin disables all but always-on outputs together
// - global disable pin high stops all but always-on outputs
// - at reset the stored configuration is copied into working registers
// - configuration store programs once; later changes go to registers
// - serial address low bit is register bit OR the pin level
// - active-high interrupt for signal loss, lock loss, calibration
// - lock-loss status high only while out of range, low in reset
// - calibration status held high through power-on or soft reset
// - live status register shows conditions driving the interrupt
// - sticky register holds live bits until host writes zero
// - register 6 bits 4, 3, 2 and 0 mask status from the interrupt
module ccs_top (
  // clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // register port
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  // configuration store programming
  input wire CFG_PROG_EN,
  input wire [2:0] CFG_PROG_ADDR,
  input wire [7:0] CFG_PROG_DATA,
  output wire CFG_PROGRAMMED,
  // clock sources
  input wire [3:0] SYNTH_CLK,
  input wire [4:0] IN_STAGE_CLK,
  // condition inputs
  input wire INPUT_SIGNAL_MISSING,
  input wire FEEDBACK_SIGNAL_MISSING,
  input wire PLL_OUT_OF_RANGE,
  input wire LOCK_DONE,
  // pins
  input wire ALL_OUTPUTS_DISABLE_PIN,
  input wire ADDR_LSB_PIN,
  output wire SERIAL_ADDR_LSB,
  output wire FAULT_INTERRUPT_PIN,
  output wire SOFT_RESET_ACTIVE,
  // outputs
  output wire [3:0] CLK_OUT,
  output wire [3:0] CLK_OUT_OE_N,
  output wire [3:0] PHASE_ALIGN_OK
);

  localparam ST_LOAD = 2'h0;
  localparam ST_CAL = 2'h1;
  localparam ST_RUN = 2'h2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] load_idx_r;
  reg [15:0] cal_cnt_r;
  reg [7:0] imask_r;
  reg [7:0] addrlsb_r;
  reg [7:0] outen_r;
  reg [7:0] softrst_r;
  reg [7:0] sticky_r;
  reg [11:0] src_sel_r;
  reg [11:0] div_sel_r;
  reg [7:0] stop_r;
  reg soft_d_r;
  reg [7:0] live_r;
  reg fault_interrupt_pin_r;
  wire [7:0] store_data;
  wire soft_rise;
  wire cal_now;
  wire [7:0] live_nxt;
  wire [3:0] lane_run;
  wire wr_sticky;
  genvar g;

  //////////////////////////////////////////////////////////////////////////
  // configuration load from store after reset

  ccs_cfg_store u_store (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .rd_addr(load_idx_r[2:0]),
    .rd_data(store_data),
    .prog_en(CFG_PROG_EN),
    .prog_addr(CFG_PROG_ADDR),
    .prog_data(CFG_PROG_DATA),
    .programmed_r(CFG_PROGRAMMED)
  );

  assign soft_rise = softrst_r[`CCS_SOFTRST_BIT] && !soft_d_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: begin
        if (load_idx_r == 4'h8) begin
          state_nxt = ST_CAL;
        end
      end
      ST_CAL: begin
        if (cal_cnt_r == `CCS_CAL_CYCLES && LOCK_DONE) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (soft_rise) begin
          state_nxt = ST_CAL;
        end
      end
      default: state_nxt = ST_LOAD;
    endcase
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_LOAD;
      load_idx_r <= 4'h0;
      cal_cnt_r <= 16'h0000;
      soft_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      soft_d_r <= softrst_r[`CCS_SOFTRST_BIT];
      if (state_r == ST_LOAD) begin
        load_idx_r <= load_idx_r + 4'h1;
      end
      if (state_r != ST_CAL) begin
        cal_cnt_r <= 16'h0000;
      end else if (cal_cnt_r != `CCS_CAL_CYCLES) begin
        cal_cnt_r <= cal_cnt_r + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // working registers; store byte k lands one cycle after index k is read

  assign wr_sticky = REG_WR && REG_ADDR == `CCS_REG_STICKY;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      imask_r <= 8'h00;
      addrlsb_r <= 8'h00;
      outen_r <= 8'h00;
      softrst_r <= 8'h00;
      src_sel_r <= 12'h000;
      div_sel_r <= 12'h000;
      stop_r <= 8'h00;
    end else if (state_r == ST_LOAD) begin
      if (load_idx_r != 4'h0) begin
        case (load_idx_r[2:0] - 3'h1)
          3'h0: imask_r <= store_data;
          3'h1: addrlsb_r <= store_data;
          3'h2: outen_r <= store_data;
          3'h3: src_sel_r[7:0] <= store_data;
          3'h4: src_sel_r[11:8] <= store_data[3:0];
          3'h5: div_sel_r[7:0] <= store_data;
          3'h6: div_sel_r[11:8] <= store_data[3:0];
          default: stop_r <= store_data;
        endcase
      end
    end else if (REG_WR) begin
      case (REG_ADDR)
        `CCS_REG_IMASK: imask_r <= REG_WDATA & `CCS_ST_MASK;
        `CCS_REG_ADDRLSB: addrlsb_r <= REG_WDATA;
        `CCS_REG_OUTEN: outen_r <= REG_WDATA;
        `CCS_REG_SOFTRST: softrst_r <= REG_WDATA;
        `CCS_REG_OUTSEL: src_sel_r[11:0] <= {REG_WDATA[5:0], src_sel_r[5:0]};
        `CCS_REG_OUTDIV0: div_sel_r[5:0] <= REG_WDATA[5:0];
        `CCS_REG_OUTDIS: stop_r <= REG_WDATA;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status, sticky and interrupt

  assign cal_now = (state_r != ST_RUN);
  assign live_nxt = {3'h0,
    PLL_OUT_OF_RANGE && !cal_now,
    FEEDBACK_SIGNAL_MISSING,
    INPUT_SIGNAL_MISSING,
    1'b0,
    cal_now};

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      live_r <= 8'h01;
      sticky_r <= 8'h00;
      fault_interrupt_pin_r <= 1'b0;
    end else begin
      live_r <= live_nxt;
      // set wins over a clear in the same cycle
      if (wr_sticky) begin
        sticky_r <= (sticky_r & REG_WDATA) | live_nxt;
      end else begin
        sticky_r <= sticky_r | live_nxt;
      end
      // registered so decode hazards never reach the pin
      fault_interrupt_pin_r <= |(live_nxt & ~imask_r & `CCS_ST_MASK);
    end
  end

  assign FAULT_INTERRUPT_PIN = fault_interrupt_pin_r;
  assign SOFT_RESET_ACTIVE = softrst_r[`CCS_SOFTRST_BIT];
  assign SERIAL_ADDR_LSB = addrlsb_r[0] | ADDR_LSB_PIN;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `CCS_REG_IMASK: REG_RDATA <= imask_r;
        `CCS_REG_ADDRLSB: REG_RDATA <= addrlsb_r;
        `CCS_REG_OUTEN: REG_RDATA <= outen_r;
        `CCS_REG_SOFTRST: REG_RDATA <= softrst_r;
        `CCS_REG_OUTSEL: REG_RDATA <= {2'h0, src_sel_r[11:6]};
        `CCS_REG_OUTDIV0: REG_RDATA <= {2'h0, div_sel_r[5:0]};
        `CCS_REG_OUTDIS: REG_RDATA <= stop_r;
        `CCS_REG_LIVE: REG_RDATA <= live_r;
        `CCS_REG_STICKY: REG_RDATA <= sticky_r;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output lanes

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      // outputs run only in run state and while the PLL is in range, when not disabled globally or alone
      assign lane_run[g] = (state_r == ST_RUN) &&
        !PLL_OUT_OF_RANGE &&
        !ALL_OUTPUTS_DISABLE_PIN &&
        !outen_r[`CCS_OUTEN_ALL] &&
        !outen_r[g];

      ccs_out_lane u_lane (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .own_clk(SYNTH_CLK[g]),
        .first_clk(SYNTH_CLK[0]),
        .in_stage(IN_STAGE_CLK),
        .src_sel(src_sel_r[3*g+2:3*g]),
        .div_sel(div_sel_r[3*g+2:3*g]),
        .stop_state(stop_r[2*g+1:2*g]),
        .run(lane_run[g]),
        .out_val(CLK_OUT[g]),
        .out_oe_n(CLK_OUT_OE_N[g]),
        .align_ok(PHASE_ALIGN_OK[g])
      );
    end
  endgenerate

endmodule // ccs_top

// *** tb/ccs_assertions.sv ***
// port-level checks on the clock output control block
`timescale 1ns/10ps
module ccs_assertions (
  // clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // register port
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  // pins
  input wire INPUT_SIGNAL_MISSING,
  input wire PLL_OUT_OF_RANGE,
  input wire ALL_OUTPUTS_DISABLE_PIN,
  input wire ADDR_LSB_PIN,
  input wire SERIAL_ADDR_LSB,
  input wire FAULT_INTERRUPT_PIN,
  input wire SOFT_RESET_ACTIVE,
  input wire [3:0] CLK_OUT,
  input wire [3:0] CLK_OUT_OE_N
);
  reg [7:0] rcnt_r;
  reg [7:0] mk_r;
  reg [7:0] od_r;
  // shadows assume a blank store, so both start at zero
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rcnt_r <= 8'h00;
      mk_r <= 8'h00;
      od_r <= 8'h00;
    end else begin
      if (rcnt_r != 8'hff)
        rcnt_r <= rcnt_r + 8'h01;
      if (REG_WR && REG_ADDR == 8'h06)
        mk_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h6e)
        od_r <= REG_WDATA;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  //////////////////////////////////////////////////////////////
  chk_lsb_pin_or: assert property (ADDR_LSB_PIN |-> SERIAL_ADDR_LSB)
    else $error("address low bit ignores the pin");
  chk_soft_set: assert property (REG_WR && REG_ADDR == 8'hf6
    && REG_WDATA == 8'h02 |-> ##[1:2] SOFT_RESET_ACTIVE)
    else $error("soft reset bit not set");
  chk_soft_hold: assert property (SOFT_RESET_ACTIVE
    && !(REG_WR && REG_ADDR == 8'hf6) |=> SOFT_RESET_ACTIVE)
    else $error("soft reset bit cleared itself");
  chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (REG_RD && REG_ADDR == 8'h55
    |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_cal_fault_interrupt_pin: assert property (rcnt_r >= 8'd20 && rcnt_r <= 8'd70
    |-> FAULT_INTERRUPT_PIN)
    else $error("interrupt low during calibration");
  chk_los_fault_interrupt_pin: assert property ($rose(INPUT_SIGNAL_MISSING)
    && !mk_r[2] |-> ##[1:3] FAULT_INTERRUPT_PIN)
    else $error("unmasked signal loss gave no interrupt");
  chk_gdis_off: assert property ($rose(ALL_OUTPUTS_DISABLE_PIN)
    && od_r == 8'h00 |-> ##[1:4] CLK_OUT_OE_N == 4'hf)
    else $error("disable pin left an output driving");
  chk_always_on: assert property ((ALL_OUTPUTS_DISABLE_PIN
    && od_r == 8'h03) [*4] |-> !CLK_OUT_OE_N[0])
    else $error("always-on output was disabled");
  chk_stop_high: assert property ((PLL_OUT_OF_RANGE
    && od_r == 8'haa) [*4] |-> CLK_OUT == 4'hf && CLK_OUT_OE_N == 4'h0)
    else $error("outputs not stopped high");
  cov_soft: cover property (REG_WR && REG_ADDR == 8'hf6);
  cov_lol: cover property ($rose(PLL_OUT_OF_RANGE));
  cov_gdis: cover property ($rose(ALL_OUTPUTS_DISABLE_PIN));
endmodule // ccs_assertions

bind ccs_top ccs_assertions u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .INPUT_SIGNAL_MISSING(INPUT_SIGNAL_MISSING),
  .PLL_OUT_OF_RANGE(PLL_OUT_OF_RANGE),
  .ALL_OUTPUTS_DISABLE_PIN(ALL_OUTPUTS_DISABLE_PIN),
  .ADDR_LSB_PIN(ADDR_LSB_PIN), .SERIAL_ADDR_LSB(SERIAL_ADDR_LSB),
  .FAULT_INTERRUPT_PIN(FAULT_INTERRUPT_PIN),
  .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE), .CLK_OUT(CLK_OUT),
  .CLK_OUT_OE_N(CLK_OUT_OE_N));

// *** tb/ccs_host.sv ***
// host controller model driving the register port
`timescale 1ns/10ps
module ccs_host (
  // clock
  input wire clk,
  // register port
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  //////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
    end
  endtask
  // bits outside the field are kept by reading first
  task rmw(input [7:0] a, input [7:0] m, input [7:0] v);
    reg [7:0] t;
    begin
      rd(a, t);
      wr(a, (t & ~m) | (v & m));
    end
  endtask
endmodule // ccs_host

// *** tb/testbench.sv ***
// self-checking bench for the clock output control block
`timescale 1ns/10ps
module testbench;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg cfg_en = 1'b0;
  reg [2:0] cfg_a = 3'h0;
  reg [7:0] cfg_d = 8'h00;
  reg [3:0] synth = 4'h5;
  reg [4:0] instg = 5'h00;
  reg los_in = 1'b0;
  reg los_fb = 1'b0;
  reg oor = 1'b0;
  reg lock_done = 1'b1;
  reg gdis = 1'b0;
  reg lsb_pin = 1'b0;
  wire wr, rd, prog, slsb, fault_interrupt_pin, srst;
  wire [7:0] addr, wdata, rdata;
  wire [3:0] clko, oen, algn;
  reg [7:0] d;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer k;
  integer j;
  integer nr;
  reg pv;
  always #5 ref_clk = ~ref_clk;
  ccs_host u_host (.clk(ref_clk), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
  ccs_top u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .REG_WR(wr),
    .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .CFG_PROG_EN(cfg_en), .CFG_PROG_ADDR(cfg_a), .CFG_PROG_DATA(cfg_d),
    .CFG_PROGRAMMED(prog), .SYNTH_CLK(synth), .IN_STAGE_CLK(instg),
    .INPUT_SIGNAL_MISSING(los_in), .FEEDBACK_SIGNAL_MISSING(los_fb),
    .PLL_OUT_OF_RANGE(oor), .LOCK_DONE(lock_done),
    .ALL_OUTPUTS_DISABLE_PIN(gdis), .ADDR_LSB_PIN(lsb_pin),
    .SERIAL_ADDR_LSB(slsb), .FAULT_INTERRUPT_PIN(fault_interrupt_pin),
    .SOFT_RESET_ACTIVE(srst), .CLK_OUT(clko), .CLK_OUT_OE_N(oen),
    .PHASE_ALIGN_OK(algn));
  //////////////////////////////////////////////////////////////
  task ck(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [7:0] a, input [7:0] exp);
    begin
      u_host.rd(a, d);
      ck(d, exp);
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #300000;
    error_cnt = error_cnt + 1;
    close_out;
  end
  initial begin
    w(20);
    rst_n <= 1'b1;
    w(30);
    ck({7'h0, fault_interrupt_pin}, 8'h01);
    rc(8'hda, 8'h01);
    w(80);
    rc(8'hda, 8'h00);
    rc(8'h06, 8'h00);
    ck({clko, oen}, 8'h50);
    ck({4'h0, algn}, 8'h0f);
    u_host.wr(8'hf7, 8'h00);
    rc(8'hf7, 8'h00);
    $display("done: load");
    u_host.wr(8'h1f, 8'h09);
    w(6);
    ck({4'h0, clko}, 8'h0d);
    for (k = 2; k < 7; k = k + 1) begin
      instg <= 5'h01 << (k - 2);
      u_host.wr(8'h1f, k[7:0]);
      w(6);
      ck({6'h0, clko[2], algn[2]}, 8'h02);
    end
    u_host.wr(8'h1f, 8'h00);
    // lane 0 source toggles each cycle; count output rises over 64 cycles
    for (k = 0; k < 3; k = k + 1) begin
      u_host.wr(8'h20, k[7:0]);
      nr = 0;
      for (j = 0; j < 72; j = j + 1) begin
        synth[0] <= ~synth[0];
        w(1);
        if (j >= 8 && clko[0] && !pv)
          nr = nr + 1;
        pv = clko[0];
      end
      ck(nr[7:0], 8'h20 >> k);
    end
    for (k = 5; k >= 0; k = k - 1) begin
      u_host.wr(8'h20, k[7:0]);
      w(6);
      ck({7'h0, algn[0]}, {7'h0, k == 0});
    end
    rc(8'h20, 8'h00);
    $display("done: source and divider");
    oor <= 1'b1;
    u_host.wr(8'h6e, 8'h55);
    w(6);
    ck({clko, oen}, 8'h00);
    u_host.wr(8'h6e, 8'haa);
    w(6);
    ck({clko, oen}, 8'hf0);
    rc(8'hda, 8'h10);
    oor <= 1'b0;
    w(4);
    rc(8'hda, 8'h00);
    rc(8'hf7, 8'h10);
    u_host.wr(8'hf7, 8'h00);
    rc(8'hf7, 8'h00);
    $display("done: stop states");
    u_host.wr(8'h06, 8'h1b);
    los_in <= 1'b1;
    w(4);
    ck({7'h0, fault_interrupt_pin}, 8'h01);
    rc(8'hda, 8'h04);
    rc(8'hf7, 8'h04);
    u_host.rmw(8'h06, 8'h04, 8'h04);
    w(4);
    ck({7'h0, fault_interrupt_pin}, 8'h00);
    rc(8'h06, 8'h1d);
    los_in <= 1'b0;
    los_fb <= 1'b1;
    w(4);
    rc(8'hda, 8'h08);
    ck({7'h0, fault_interrupt_pin}, 8'h00);
    los_fb <= 1'b0;
    u_host.wr(8'h06, 8'h00);
    $display("done: interrupt");
    u_host.wr(8'h6e, 8'h00);
    gdis <= 1'b1;
    w(6);
    ck({4'h0, oen}, 8'h0f);
    u_host.wr(8'h6e, 8'h03);
    w(6);
    ck({4'h0, oen}, 8'h0e);
    gdis <= 1'b0;
    u_host.wr(8'h6e, 8'h00);
    u_host.wr(8'he6, 8'h01);
    w(6);
    ck({4'h0, oen}, 8'h01);
    u_host.wr(8'he6, 8'h10);
    w(6);
    ck({4'h0, oen}, 8'h0f);
    u_host.wr(8'he6, 8'h00);
    $display("done: enables");
    lsb_pin <= 1'b1;
    w(2);
    ck({7'h0, slsb}, 8'h01);
    lsb_pin <= 1'b0;
    w(2);
    ck({7'h0, slsb}, 8'h00);
    u_host.wr(8'h1b, 8'h01);
    w(2);
    ck({7'h0, slsb}, 8'h01);
    u_host.wr(8'h55, 8'hff);
    rc(8'h55, 8'h00);
    // soft reset keeps register values and reruns calibration only
    lock_done <= 1'b0;
    u_host.wr(8'hf6, 8'h02);
    w(3);
    ck({7'h0, srst}, 8'h01);
    rc(8'hf6, 8'h02);
    rc(8'hda, 8'h01);
    w(80);
    rc(8'hda, 8'h01);
    lock_done <= 1'b1;
    w(4);
    rc(8'hda, 8'h00);
    u_host.wr(8'hf6, 8'h00);
    cfg_en <= 1'b1;
    cfg_d <= 8'h1c;
    w(1);
    cfg_a <= 3'h7;
    cfg_d <= 8'h00;
    w(1);
    // second programming of byte 0 must be ignored
    cfg_a <= 3'h0;
    w(1);
    cfg_en <= 1'b0;
    w(3);
    ck({7'h0, prog}, 8'h01);
    rst_n <= 1'b0;
    w(3);
    rst_n <= 1'b1;
    w(90);
    rc(8'h06, 8'h1c);
    rc(8'hda, 8'h00);
    $display("done: pins and store");
    close_out;
  end
endmodule // testbench
